// ===== rtl/iprb_bank.sv
// Priority register bank slice with APB slave and priority outputs
//
// Behaviour
// - Three-bit priority, 7 highest, 000 disables
// - Every field resets to binary 100
// - Unimplemented bits read zero, ignore writes
// - Register one: OC7, OC6, OC5, IC6
// - Register two: DMA4 at 10-8
// - Register two: parallel port at 6-4
// - Register three: I2C master, slave fields
// - Register four: ext irq 4 and 3
// - Register five: clock alarm, DMA5 fields
`timescale 1ns/100ps
module iprb_bank (
  input  wire logic        CORE_CLK,
  input  wire logic        SRST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  input  wire logic [3:0]  PSTRB,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic      [2:0]  OUT_COMPARE7_PRIO,
  output logic      [2:0]  OUT_COMPARE6_PRIO,
  output logic      [2:0]  OUT_COMPARE5_PRIO,
  output logic      [2:0]  IN_CAPTURE6_PRIO,
  output logic      [2:0]  DMA_CH4_PRIO,
  output logic      [2:0]  PARALLEL_PORT_PRIO,
  output logic      [2:0]  I2C_B_MASTER_PRIO,
  output logic      [2:0]  I2C_B_SLAVE_PRIO,
  output logic      [2:0]  EXT_IRQ4_PRIO,
  output logic      [2:0]  EXT_IRQ3_PRIO,
  output logic      [2:0]  CLOCK_ALARM_PRIO,
  output logic      [2:0]  DMA_CH5_PRIO,
  output logic      [11:0] PRIO_ENABLED
);
  typedef struct packed {
    logic [31:0] rdata_r;
    logic        err_r;
  } iprb_st_s;

  localparam int NR = iprb_pkg::NUM_REGS;
  localparam logic [NR*16-1:0] MASKS = {iprb_pkg::MASK_CLKDMA, iprb_pkg::MASK_EXTIRQ,
                                        iprb_pkg::MASK_I2CB, iprb_pkg::MASK_DMAPP,
                                        iprb_pkg::MASK_CCPA};
  localparam logic [NR*16-1:0] RSTS  = {iprb_pkg::RST_PAIR, iprb_pkg::RST_PAIR,
                                        iprb_pkg::RST_PAIR, iprb_pkg::RST_PAIR,
                                        iprb_pkg::RST_CCPA};

  iprb_st_s    st_r;
  iprb_st_s    st_nxt;
  logic [15:0] word   [NR];
  logic [NR-1:0] wr_sel;
  logic [NR-1:0] hit;
  logic        access;

  // Address decode, used for both writes and reads
  function automatic logic [NR-1:0] dec(input logic [11:0] a);
    logic [NR-1:0] d;
    d = '0;
    case (a)
      iprb_pkg::OFF_CCPA:   d[0] = 1'b1;
      iprb_pkg::OFF_DMAPP:  d[1] = 1'b1;
      iprb_pkg::OFF_I2CB:   d[2] = 1'b1;
      iprb_pkg::OFF_EXTIRQ: d[3] = 1'b1;
      iprb_pkg::OFF_CLKDMA: d[4] = 1'b1;
      default:              d = '0;
    endcase
    return d;
  endfunction

  // Slave answers in the first access cycle, no wait states
  assign access = PSEL && PENABLE;
  assign hit    = dec(PADDR);
  assign PREADY = 1'b1;

  // Writes land only with both low byte lanes enabled
  genvar g;
  generate
    for (g = 0; g < NR; g++) begin : g_reg
      assign wr_sel[g] = access && PWRITE && hit[g] && (PSTRB[1:0] == 2'h3);
      iprb_word_reg #(
        .MASK (MASKS[g*16 +: 16]),
        .RSTV (RSTS[g*16 +: 16])
      ) u_reg (
        .CORE_CLK (CORE_CLK),
        .SRST     (SRST),
        .wr_en    (wr_sel[g]),
        .wr_data  (PWDATA[15:0]),
        .q        (word[g])
      );
    end
  endgenerate

  // Read data registered; unmapped access flags an error
  always_comb begin
    st_nxt = st_r;
    st_nxt.err_r = 1'b0;
    if (PSEL && !PENABLE) begin
      st_nxt.rdata_r = '0;
      st_nxt.err_r   = (hit == '0);
      for (int i = 0; i < NR; i++) begin
        if (hit[i] && !PWRITE) begin
          st_nxt.rdata_r = {16'h0000, word[i]};
        end
      end
    end
  end

  // Registered read path; reset clears data and error
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      st_r <= '{rdata_r: 32'h0000_0000, err_r: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign PRDATA  = st_r.rdata_r;
  assign PSLVERR = access && st_r.err_r;

  // Field placement, straight from stored words to arbitration
  assign OUT_COMPARE7_PRIO  = word[0][iprb_pkg::FLD_HI  +: iprb_pkg::PRIO_W];
  assign OUT_COMPARE6_PRIO  = word[0][iprb_pkg::FLD_MID +: iprb_pkg::PRIO_W];
  assign OUT_COMPARE5_PRIO  = word[0][iprb_pkg::FLD_LOW +: iprb_pkg::PRIO_W];
  assign IN_CAPTURE6_PRIO   = word[0][iprb_pkg::FLD_BOT +: iprb_pkg::PRIO_W];
  assign DMA_CH4_PRIO       = word[1][iprb_pkg::FLD_MID +: iprb_pkg::PRIO_W];
  assign PARALLEL_PORT_PRIO = word[1][iprb_pkg::FLD_LOW +: iprb_pkg::PRIO_W];
  assign I2C_B_MASTER_PRIO  = word[2][iprb_pkg::FLD_MID +: iprb_pkg::PRIO_W];
  assign I2C_B_SLAVE_PRIO   = word[2][iprb_pkg::FLD_LOW +: iprb_pkg::PRIO_W];
  assign EXT_IRQ4_PRIO      = word[3][iprb_pkg::FLD_MID +: iprb_pkg::PRIO_W];
  assign EXT_IRQ3_PRIO      = word[3][iprb_pkg::FLD_LOW +: iprb_pkg::PRIO_W];
  assign CLOCK_ALARM_PRIO   = word[4][iprb_pkg::FLD_MID +: iprb_pkg::PRIO_W];
  assign DMA_CH5_PRIO       = word[4][iprb_pkg::FLD_LOW +: iprb_pkg::PRIO_W];

  // Code 000 takes a source out of arbitration entirely
  assign PRIO_ENABLED = {
    |DMA_CH5_PRIO, |CLOCK_ALARM_PRIO, |EXT_IRQ3_PRIO, |EXT_IRQ4_PRIO,
    |I2C_B_SLAVE_PRIO, |I2C_B_MASTER_PRIO, |PARALLEL_PORT_PRIO, |DMA_CH4_PRIO,
    |IN_CAPTURE6_PRIO, |OUT_COMPARE5_PRIO, |OUT_COMPARE6_PRIO, |OUT_COMPARE7_PRIO
  };

  // Enable summary tracks each field's code, in fixed bit order
  AST_DISABLE: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (DMA_CH5_PRIO == iprb_pkg::PRIO_OFF) |-> !PRIO_ENABLED[11])
    else $error("Disabled source still enabled");
  AST_EN_OC7: assert property (@(posedge CORE_CLK) disable iff (SRST)
    PRIO_ENABLED[0] == (OUT_COMPARE7_PRIO != iprb_pkg::PRIO_OFF))
    else $error("Enable bit 0 wrong");
  AST_EN_OC6: assert property (@(posedge CORE_CLK) disable iff (SRST)
    PRIO_ENABLED[1] == (OUT_COMPARE6_PRIO != iprb_pkg::PRIO_OFF))
    else $error("Enable bit 1 wrong");
  AST_EN_OC5: assert property (@(posedge CORE_CLK) disable iff (SRST)
    PRIO_ENABLED[2] == (OUT_COMPARE5_PRIO != iprb_pkg::PRIO_OFF))
    else $error("Enable bit 2 wrong");
  AST_EN_IC6: assert property (@(posedge CORE_CLK) disable iff (SRST)
    PRIO_ENABLED[3] == (IN_CAPTURE6_PRIO != iprb_pkg::PRIO_OFF))
    else $error("Enable bit 3 wrong");
  AST_EN_DMA4: assert property (@(posedge CORE_CLK) disable iff (SRST)
    PRIO_ENABLED[4] == (DMA_CH4_PRIO != iprb_pkg::PRIO_OFF))
    else $error("Enable bit 4 wrong");
  AST_EN_PP: assert property (@(posedge CORE_CLK) disable iff (SRST)
    PRIO_ENABLED[5] == (PARALLEL_PORT_PRIO != iprb_pkg::PRIO_OFF))
    else $error("Enable bit 5 wrong");
  AST_EN_I2CM: assert property (@(posedge CORE_CLK) disable iff (SRST)
    PRIO_ENABLED[6] == (I2C_B_MASTER_PRIO != iprb_pkg::PRIO_OFF))
    else $error("Enable bit 6 wrong");
  AST_EN_I2CS: assert property (@(posedge CORE_CLK) disable iff (SRST)
    PRIO_ENABLED[7] == (I2C_B_SLAVE_PRIO != iprb_pkg::PRIO_OFF))
    else $error("Enable bit 7 wrong");
  AST_EN_EXT4: assert property (@(posedge CORE_CLK) disable iff (SRST)
    PRIO_ENABLED[8] == (EXT_IRQ4_PRIO != iprb_pkg::PRIO_OFF))
    else $error("Enable bit 8 wrong");
  AST_EN_EXT3: assert property (@(posedge CORE_CLK) disable iff (SRST)
    PRIO_ENABLED[9] == (EXT_IRQ3_PRIO != iprb_pkg::PRIO_OFF))
    else $error("Enable bit 9 wrong");
  AST_EN_RTC: assert property (@(posedge CORE_CLK) disable iff (SRST)
    PRIO_ENABLED[10] == (CLOCK_ALARM_PRIO != iprb_pkg::PRIO_OFF))
    else $error("Enable bit 10 wrong");
  AST_EN_DMA5: assert property (@(posedge CORE_CLK) disable iff (SRST)
    PRIO_ENABLED[11] == (DMA_CH5_PRIO != iprb_pkg::PRIO_OFF))
    else $error("Enable bit 11 wrong");

  // Sync reset: the edge after SRST shows every word at its reset value
  AST_RESET: assert property (@(posedge CORE_CLK)
    SRST |=> (word[0] == iprb_pkg::RST_CCPA && EXT_IRQ3_PRIO == iprb_pkg::PRIO_RST))
    else $error("Reset value wrong");
  AST_RST_W1: assert property (@(posedge CORE_CLK)
    SRST |=> (word[1] == iprb_pkg::RST_PAIR))
    else $error("Reset value wrong in word 1");
  AST_RST_W2: assert property (@(posedge CORE_CLK)
    SRST |=> (word[2] == iprb_pkg::RST_PAIR))
    else $error("Reset value wrong in word 2");
  AST_RST_W3: assert property (@(posedge CORE_CLK)
    SRST |=> (word[3] == iprb_pkg::RST_PAIR))
    else $error("Reset value wrong in word 3");
  AST_RST_W4: assert property (@(posedge CORE_CLK)
    SRST |=> (word[4] == iprb_pkg::RST_PAIR))
    else $error("Reset value wrong in word 4");

  // Gap and unused bits never hold a one, whatever was written
  AST_GAPS: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (word[1] & ~iprb_pkg::MASK_DMAPP) == 16'h0000 && word[0][15] == 1'b0)
    else $error("Unimplemented bit set");
  AST_GAP_W0: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (word[0] & ~iprb_pkg::MASK_CCPA) == 16'h0000)
    else $error("Unimplemented bit set in word 0");
  AST_GAP_W2: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (word[2] & ~iprb_pkg::MASK_I2CB) == 16'h0000)
    else $error("Unimplemented bit set in word 2");
  AST_GAP_W3: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (word[3] & ~iprb_pkg::MASK_EXTIRQ) == 16'h0000)
    else $error("Unimplemented bit set in word 3");
  AST_GAP_W4: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (word[4] & ~iprb_pkg::MASK_CLKDMA) == 16'h0000)
    else $error("Unimplemented bit set in word 4");

  // Each written field lands on its own output one edge later
  AST_OC7: assert property (@(posedge CORE_CLK) disable iff (SRST)
    wr_sel[0] |=> OUT_COMPARE7_PRIO == $past(PWDATA[14:12]))
    else $error("OC7 field misplaced");
  AST_OC6: assert property (@(posedge CORE_CLK) disable iff (SRST)
    wr_sel[0] |=> OUT_COMPARE6_PRIO == $past(PWDATA[10:8]))
    else $error("OC6 field misplaced");
  AST_OC5: assert property (@(posedge CORE_CLK) disable iff (SRST)
    wr_sel[0] |=> OUT_COMPARE5_PRIO == $past(PWDATA[6:4]))
    else $error("OC5 field misplaced");
  AST_IC6: assert property (@(posedge CORE_CLK) disable iff (SRST)
    wr_sel[0] |=> IN_CAPTURE6_PRIO == $past(PWDATA[2:0]))
    else $error("IC6 field misplaced");
  AST_DMA4: assert property (@(posedge CORE_CLK) disable iff (SRST)
    wr_sel[1] |=> DMA_CH4_PRIO == $past(PWDATA[10:8]))
    else $error("DMA4 field misplaced");
  AST_PMP: assert property (@(posedge CORE_CLK) disable iff (SRST)
    wr_sel[1] |=> PARALLEL_PORT_PRIO == $past(PWDATA[6:4]) && word[1][3:0] == 4'h0)
    else $error("Parallel port field misplaced");
  AST_I2CM: assert property (@(posedge CORE_CLK) disable iff (SRST)
    wr_sel[2] |=> I2C_B_MASTER_PRIO == $past(PWDATA[10:8]))
    else $error("I2C master field misplaced");
  AST_I2C: assert property (@(posedge CORE_CLK) disable iff (SRST)
    wr_sel[2] |=> I2C_B_SLAVE_PRIO == $past(PWDATA[6:4]))
    else $error("I2C slave field misplaced");
  AST_EXT: assert property (@(posedge CORE_CLK) disable iff (SRST)
    wr_sel[3] |=> EXT_IRQ4_PRIO == $past(PWDATA[10:8]))
    else $error("Ext irq4 field misplaced");
  AST_EXT3: assert property (@(posedge CORE_CLK) disable iff (SRST)
    wr_sel[3] |=> EXT_IRQ3_PRIO == $past(PWDATA[6:4]))
    else $error("Ext irq3 field misplaced");
  AST_RTC: assert property (@(posedge CORE_CLK) disable iff (SRST)
    wr_sel[4] |=> CLOCK_ALARM_PRIO == $past(PWDATA[10:8]))
    else $error("Clock alarm field misplaced");
  AST_DMA5: assert property (@(posedge CORE_CLK) disable iff (SRST)
    wr_sel[4] |=> DMA_CH5_PRIO == $past(PWDATA[6:4]))
    else $error("DMA5 field misplaced");

  // No write, no change; a reset edge is left out since it reloads
  AST_HOLD: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (!SRST && wr_sel == '0) |=> $stable(word[2]))
    else $error("Field changed without write");
  AST_HOLD_W0: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (!SRST && !wr_sel[0]) |=> $stable(word[0]))
    else $error("Word 0 changed without write");
  AST_HOLD_W1: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (!SRST && !wr_sel[1]) |=> $stable(word[1]))
    else $error("Word 1 changed without write");
  AST_HOLD_W3: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (!SRST && !wr_sel[3]) |=> $stable(word[3]))
    else $error("Word 3 changed without write");
  AST_HOLD_W4: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (!SRST && !wr_sel[4]) |=> $stable(word[4]))
    else $error("Word 4 changed without write");

  // Read data captured at setup stands in the access cycle
  AST_RDBK: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (PSEL && !PENABLE && !PWRITE && hit[3]) |=> PRDATA == {16'h0000, word[3]})
    else $error("Readback mismatch");
  AST_RDBK_W0: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (PSEL && !PENABLE && !PWRITE && hit[0]) |=> PRDATA == {16'h0000, word[0]})
    else $error("Readback mismatch in word 0");
  AST_RDBK_W1: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (PSEL && !PENABLE && !PWRITE && hit[1]) |=> PRDATA == {16'h0000, word[1]})
    else $error("Readback mismatch in word 1");
  AST_RDBK_W2: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (PSEL && !PENABLE && !PWRITE && hit[2]) |=> PRDATA == {16'h0000, word[2]})
    else $error("Readback mismatch in word 2");
  AST_RDBK_W4: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (PSEL && !PENABLE && !PWRITE && hit[4]) |=> PRDATA == {16'h0000, word[4]})
    else $error("Readback mismatch in word 4");

  // Refused accesses: unmapped flags an error, neither kind stores
  AST_ERR: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (PSEL && !PENABLE && hit == '0) |=> (PSLVERR == (PSEL && PENABLE) && PRDATA == '0))
    else $error("Unmapped access not flagged");
  AST_NOERR: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (PSEL && !PENABLE && hit != '0) |=> !PSLVERR)
    else $error("Mapped access flagged");
  AST_STRB: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (!SRST && PSEL && PENABLE && PWRITE && PSTRB[1:0] != 2'h3) |=>
      ($stable(word[0]) && $stable(word[1]) && $stable(word[2]) &&
       $stable(word[3]) && $stable(word[4])))
    else $error("Partial strobe write stored");
  AST_UNMAP: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (!SRST && PSEL && PENABLE && PWRITE && hit == '0) |=>
      ($stable(word[0]) && $stable(word[1]) && $stable(word[2]) &&
       $stable(word[3]) && $stable(word[4])))
    else $error("Unmapped write stored");
endmodule

// ===== rtl/iprb_pkg.sv
// Package for the interrupt priority register bank slice
package iprb_pkg;
  localparam int          PRIO_W      = 3;
  localparam int          NUM_REGS    = 5;
  localparam int          IDX_W       = 3;
  localparam logic [11:0] OFF_CCPA    = 12'h000;
  localparam logic [11:0] OFF_DMAPP   = 12'h004;
  localparam logic [11:0] OFF_I2CB    = 12'h008;
  localparam logic [11:0] OFF_EXTIRQ  = 12'h00C;
  localparam logic [11:0] OFF_CLKDMA  = 12'h010;
  localparam logic [2:0]  PRIO_RST    = 3'h4;
  localparam logic [2:0]  PRIO_OFF    = 3'h0;
  localparam int          FLD_HI      = 12;
  localparam int          FLD_MID     = 8;
  localparam int          FLD_LOW     = 4;
  localparam int          FLD_BOT     = 0;
  // Writable bit masks per register, fields of three with gaps
  localparam logic [15:0] MASK_CCPA   = 16'h7777;
  localparam logic [15:0] MASK_DMAPP  = 16'h0770;
  localparam logic [15:0] MASK_I2CB   = 16'h0770;
  localparam logic [15:0] MASK_EXTIRQ = 16'h0770;
  localparam logic [15:0] MASK_CLKDMA = 16'h0770;
  localparam logic [15:0] RST_CCPA    = 16'h4444;
  localparam logic [15:0] RST_PAIR    = 16'h0440;
  localparam logic [2:0]  ST_IDLE     = 3'h0;
endpackage

// ===== rtl/iprb_word_reg.sv
// One masked priority register word with reset value
`timescale 1ns/100ps
module iprb_word_reg #(
  parameter logic [15:0] MASK = 16'hFFFF,
  parameter logic [15:0] RSTV = 16'h0000
) (
  input  wire logic        CORE_CLK,
  input  wire logic        SRST,
  input  wire logic        wr_en,
  input  wire logic [15:0] wr_data,
  output logic      [15:0] q
);
  typedef struct packed {
    logic [15:0] word_r;
  } iprb_wst_s;

  iprb_wst_s st_r;
  iprb_wst_s st_nxt;

  // Unimplemented bits never store, so they read as zero
  always_comb begin
    st_nxt = st_r;
    if (wr_en) begin
      st_nxt.word_r = wr_data & MASK;
    end
  end

  // Reset loads priority 4 in every field
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      st_r <= '{word_r: RSTV};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.word_r;
endmodule

// ===== tb/tb.sv
// Self-checking bench for the priority register bank slice
`timescale 1ns/100ps
module tb;
  logic        clk, srst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr, en;
  logic [31:0] pwdata, prdata, lf;
  logic [3:0]  pstrb;
  logic [2:0]  pr [12];
  logic [15:0] exp_w [5];
  logic [32:0] q [$];
  int          fail_count, n_checks;

  iprb_bank u_iprb_bank (.CORE_CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .OUT_COMPARE7_PRIO(pr[0]), .OUT_COMPARE6_PRIO(pr[1]),
    .OUT_COMPARE5_PRIO(pr[2]), .IN_CAPTURE6_PRIO(pr[3]), .DMA_CH4_PRIO(pr[4]),
    .PARALLEL_PORT_PRIO(pr[5]), .I2C_B_MASTER_PRIO(pr[6]), .I2C_B_SLAVE_PRIO(pr[7]),
    .EXT_IRQ4_PRIO(pr[8]), .EXT_IRQ3_PRIO(pr[9]), .CLOCK_ALARM_PRIO(pr[10]),
    .DMA_CH5_PRIO(pr[11]), .PRIO_ENABLED(en));

  // Free-running core clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Writable bits of each word; gap bits must stay zero
  function logic [15:0] msk(input int k);
    return (k == 0) ? 16'h7777 : 16'h0770;
  endfunction

  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input logic [32:0] seen, input logic [32:0] want);
    n_checks++;
    if (seen !== want) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  // One APB transfer; extra idle edge keeps strobes from double assignment
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (pready !== 1'b1) begin
      fail_count++;
      complete_run;
    end
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask

  task rdall;
    for (int k = 0; k < 5; k++) begin
      q.push_back({1'b0, 16'h0, exp_w[k]});
      apb(1'b0, 12'(k * 4), 32'h0, 4'hF);
    end
  endtask

  // Outputs regrouped per register word, plus the enable summary
  task ports;
    logic [11:0] e;
    @(negedge clk); // Settled, away from the launching edge
    chk({17'h0, 1'b0, pr[0], 1'b0, pr[1], 1'b0, pr[2], 1'b0, pr[3]}, {17'h0, exp_w[0]});
    for (int k = 1; k < 5; k++)
      chk({22'h0, pr[2*k+2], 1'b0, pr[2*k+3], 4'h0}, {17'h0, exp_w[k]});
    for (int j = 0; j < 12; j++)
      e[j] = (j < 4) ? |exp_w[0][12-4*j +: 3] : |exp_w[(j-2)/2][8-4*(j%2) +: 3];
    chk({21'h0, en}, {21'h0, e});
    chk({31'h0, pready, pslverr}, 33'h2);
    @(posedge clk);
  endtask

  // Scoreboard: each completed read takes the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0)
      chk({pslverr, prdata}, q.pop_front());
  end

  initial begin
    srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; pstrb = 4'h0; lf = 32'h98d1;
    for (int k = 0; k < 5; k++) exp_w[k] = (k == 0) ? 16'h4444 : 16'h0440;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    ports;
    rdall;
    $display("test reset values done");
    repeat (3) begin
      for (int k = 0; k < 5; k++) begin
        lf = lfsr(lf);
        apb(1'b1, 12'(k * 4), lf, 4'hF);
        exp_w[k] = lf[15:0] & msk(k);
      end
      ports;
      rdall;
    end
    $display("test random words done");
    for (int c = 0; c < 8; c++) begin
      for (int k = 0; k < 5; k++) begin
        apb(1'b1, 12'(k * 4), {16'h0, {4{1'b0, c[2:0]}}}, 4'hF);
        exp_w[k] = {4{1'b0, c[2:0]}} & msk(k);
      end
      ports;
      rdall;
    end
    $display("test every code done");
    // Zero data, so a wrongly stored write shows against code 7
    apb(1'b1, 12'h000, 32'h00000000, 4'h1);
    apb(1'b1, 12'h014, 32'h00000000, 4'hF);
    q.push_back({1'b1, 32'h0});
    apb(1'b0, 12'h014, 32'h0, 4'hF);
    ports;
    rdall;
    $display("test refused accesses done");
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    for (int k = 0; k < 5; k++) exp_w[k] = (k == 0) ? 16'h4444 : 16'h0440;
    ports;
    chk({pslverr, prdata}, 33'h0);
    rdall;
    $display("test second reset done");
    complete_run;
  end
endmodule
